/* File: adc_ctrl_pkg.sv */
// Package with register map, field layout and types of the converter control block
package adc_ctrl_pkg;
   // Bus and register geometry
   localparam int unsigned ADDR_W   = 18;
   localparam int unsigned DATA_W   = 32;
   localparam int unsigned REG_W    = 8;
   localparam int unsigned RESULT_W = 10;

   // Register indices; byte address is four times the index
   localparam logic [15:0] IDX_IRQ_PRIORITY = 16'hff28;
   localparam logic [15:0] IDX_IRQ_ENABLE   = 16'hff2a;
   localparam logic [15:0] IDX_IRQ_FLAG     = 16'hff2c;
   localparam logic [15:0] IDX_CLOCK_CTRL   = 16'hff80;
   localparam logic [15:0] IDX_PIN_SELECT   = 16'hff81;
   localparam logic [15:0] IDX_START_CHAN   = 16'hff82;
   localparam logic [15:0] IDX_RESULT_HIGH  = 16'hff83;
   localparam logic [15:0] IDX_RESULT_LOW   = 16'hff84;

   // Field positions
   localparam int unsigned PRIO_LSB      = 6;
   localparam int unsigned ENABLE_BIT    = 7;
   localparam int unsigned FLAG_BIT      = 7;
   localparam int unsigned PRESCALE_LSB  = 0;
   localparam int unsigned GATE_BIT      = 3;
   localparam int unsigned PIN_SEL_LSB   = 4;
   localparam int unsigned START_BIT     = 7;
   localparam int unsigned CHAN_LSB      = 0;
   localparam int unsigned RESULT_LO_W   = 2;

   // Values after reset
   localparam logic [1:0] PRIO_RST     = 2'h0;
   localparam logic [2:0] PRESCALE_RST = 3'h0;
   localparam logic [3:0] PIN_SEL_RST  = 4'h0;
   localparam logic [1:0] CHAN_RST     = 2'h0;

   // Prescaler code that picks the undivided slow clock
   localparam logic [2:0] PRESCALE_SLOW = 3'h7;
   localparam int unsigned PRESCALE_CNT_W = 6;

   // Conversion sequencing state
   typedef enum logic {
      CONV_IDLE = 1'b0,
      CONV_BUSY = 1'b1
   } conv_state_t;

   // Control bundle towards the analog core
   typedef struct packed {
      logic [3:0] pin_sel;
      logic [1:0] channel;
      logic       start;
      logic       busy;
   } conv_ctrl_t;
endpackage : adc_ctrl_pkg

/* File: adc_prescaler.sv */
// Prescaler that divides the oscillator ticks and gates the converter clock
`timescale 1ns/1ps
module adc_prescaler #(
   parameter int unsigned CNT_W = adc_ctrl_pkg::PRESCALE_CNT_W
) (
   input  wire logic       clk_i,
   input  wire logic       resetn_i,
   input  wire logic       fast_tick_i,
   input  wire logic       slow_tick_i,
   input  wire logic [2:0] sel_i,
   input  wire logic       gate_i,
   output logic            tick_o
);
   logic [CNT_W-1:0] cnt_q;
   logic [CNT_W-1:0] mask;

   // Terminal count mask for ratios 1 to 64
   assign mask = CNT_W'((1 << sel_i) - 1);

   // Fast tick counter, held clear while gated off
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         cnt_q <= '0;
      end else if (!gate_i) begin
         cnt_q <= '0;
      end else if (fast_tick_i) begin
         cnt_q <= cnt_q + CNT_W'(1);
      end
   end

   // Clock tick to the converter
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         tick_o <= 1'b0;
      end else if (!gate_i) begin
         tick_o <= 1'b0;
      end else if (sel_i == adc_ctrl_pkg::PRESCALE_SLOW) begin
         tick_o <= slow_tick_i;
      end else begin
         tick_o <= fast_tick_i && ((cnt_q & mask) == mask);
      end
   end

   gate_off_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
      !gate_i |=> !tick_o) else $error("tick while gate is off");
   slow_pass_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
      gate_i && sel_i == 3'h7 |=> tick_o == $past(slow_tick_i))
      else $error("slow clock not passed through");
   undivided_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
      gate_i && sel_i == 3'h0 |=> tick_o == $past(fast_tick_i))
      else $error("divide by one broken");
endmodule : adc_prescaler

/* File: adc_irq_gate.sv */
// Interrupt request gating by enable and priority against the CPU mask
`timescale 1ns/1ps
module adc_irq_gate (
   input  wire logic       clk_i,
   input  wire logic       resetn_i,
   input  wire logic       flag_i,
   input  wire logic       enable_i,
   input  wire logic [1:0] level_i,
   input  wire logic [1:0] cpu_mask_i,
   output logic            irq_o,
   output logic            req_o
);
   // Level interrupt and priority qualified request
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         irq_o <= 1'b0;
         req_o <= 1'b0;
      end else begin
         irq_o <= flag_i && enable_i;
         req_o <= flag_i && enable_i && (level_i > cpu_mask_i);
      end
   end

   req_cause_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
      req_o |-> $past(flag_i) && $past(enable_i) && ($past(level_i) > $past(cpu_mask_i)))
      else $error("request without its cause");
   level0_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
      level_i == 2'h0 |=> !req_o) else $error("level 0 raised a request");
endmodule : adc_irq_gate

/* File: adc_control.sv */
// Converter control registers, sequencing and interrupt over an Avalon-MM slave
`timescale 1ns/1ps
module adc_control (
   input  wire logic                                 clk_i,
   input  wire logic                                 resetn_i,
   // Avalon-MM slave
   input  wire logic [adc_ctrl_pkg::ADDR_W-1:0]      address_i,
   input  wire logic                                 read_i,
   input  wire logic                                 write_i,
   input  wire logic [adc_ctrl_pkg::DATA_W-1:0]      writedata_i,
   input  wire logic [3:0]                           byteenable_i,
   output logic      [adc_ctrl_pkg::DATA_W-1:0]      readdata_o,
   output logic                                      waitrequest_o,
   // Oscillator ticks and converter core
   input  wire logic                                 fast_tick_i,
   input  wire logic                                 slow_tick_i,
   input  wire logic                                 conv_done_i,
   input  wire logic [adc_ctrl_pkg::RESULT_W-1:0]    conv_result_i,
   output adc_ctrl_pkg::conv_ctrl_t                  conv_ctrl_o,
   output logic                                      conv_clk_tick_o,
   // CPU interrupt side
   input  wire logic [1:0]                           cpu_mask_i,
   output logic [1:0]                                irq_level_o,
   output logic                                      irq_o,
   output logic                                      irq_req_o
);
   logic [1:0]                          prio_q;
   logic                                enable_q;
   logic                                flag_q;
   logic [2:0]                          prescale_q;
   logic                                gate_q;
   logic [3:0]                          pin_sel_q;
   logic [1:0]                          chan_q;
   logic                                start_q;
   logic [adc_ctrl_pkg::RESULT_W-1:0]   result_q;
   adc_ctrl_pkg::conv_state_t           state_q;
   adc_ctrl_pkg::conv_state_t           state_d;
   logic                                wait_q;
   logic [adc_ctrl_pkg::DATA_W-1:0]     rdata_q;
   logic [adc_ctrl_pkg::REG_W-1:0]      rdata_d;
   logic [15:0]                         idx;
   logic                                wr_en;
   logic                                rd_cap;
   logic [adc_ctrl_pkg::REG_W-1:0]      wdata;

   // Bus decode; a write takes effect on the acknowledging edge
   assign idx    = address_i[adc_ctrl_pkg::ADDR_W-1:2];
   assign wdata  = writedata_i[adc_ctrl_pkg::REG_W-1:0];
   assign wr_en  = write_i && !wait_q && byteenable_i[0];
   assign rd_cap = read_i && wait_q;

   // Waitrequest drops for exactly one cycle per request
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         wait_q <= 1'b1;
      end else begin
         wait_q <= !((read_i || write_i) && wait_q);
      end
   end

   // Read multiplexer; unmapped and reserved bits read zero
   always_comb begin
      rdata_d = '0;
      case (idx)
         adc_ctrl_pkg::IDX_IRQ_PRIORITY: begin
            rdata_d[adc_ctrl_pkg::PRIO_LSB +: 2] = prio_q;
         end
         adc_ctrl_pkg::IDX_IRQ_ENABLE: begin
            rdata_d[adc_ctrl_pkg::ENABLE_BIT] = enable_q;
         end
         adc_ctrl_pkg::IDX_IRQ_FLAG: begin
            rdata_d[adc_ctrl_pkg::FLAG_BIT] = flag_q;
         end
         adc_ctrl_pkg::IDX_CLOCK_CTRL: begin
            rdata_d[adc_ctrl_pkg::PRESCALE_LSB +: 3] = prescale_q;
         end
         adc_ctrl_pkg::IDX_PIN_SELECT: begin
            rdata_d[adc_ctrl_pkg::PIN_SEL_LSB +: 4] = pin_sel_q;
         end
         adc_ctrl_pkg::IDX_START_CHAN: begin
            rdata_d[adc_ctrl_pkg::CHAN_LSB +: 2] = chan_q;
         end
         adc_ctrl_pkg::IDX_RESULT_HIGH: begin
            rdata_d = result_q[adc_ctrl_pkg::RESULT_W-1:adc_ctrl_pkg::RESULT_LO_W];
         end
         adc_ctrl_pkg::IDX_RESULT_LOW: begin
            rdata_d[adc_ctrl_pkg::RESULT_LO_W-1:0] = result_q[adc_ctrl_pkg::RESULT_LO_W-1:0];
         end
         default: begin
            rdata_d = '0;
         end
      endcase
   end

   // Read data registered one cycle after the request
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         rdata_q <= '0;
      end else if (rd_cap) begin
         rdata_q <= {{(adc_ctrl_pkg::DATA_W-adc_ctrl_pkg::REG_W){1'b0}}, rdata_d};
      end
   end

   // Interrupt priority; reserved bits are not stored
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         prio_q <= adc_ctrl_pkg::PRIO_RST;
      end else if (wr_en && idx == adc_ctrl_pkg::IDX_IRQ_PRIORITY) begin
         prio_q <= wdata[adc_ctrl_pkg::PRIO_LSB +: 2];
      end
   end

   // Interrupt enable, masks the interrupt but not the status flag
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         enable_q <= 1'b0;
      end else if (wr_en && idx == adc_ctrl_pkg::IDX_IRQ_ENABLE) begin
         enable_q <= wdata[adc_ctrl_pkg::ENABLE_BIT];
      end
   end

   // Completion flag; a completion beats a clearing write
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         flag_q <= 1'b0;
      end else if (conv_done_i) begin
         flag_q <= 1'b1;
      end else if (wr_en && idx == adc_ctrl_pkg::IDX_IRQ_FLAG
                   && wdata[adc_ctrl_pkg::FLAG_BIT]) begin
         flag_q <= 1'b0;
      end
   end

   // Prescaler select and clock gate
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         prescale_q <= adc_ctrl_pkg::PRESCALE_RST;
         gate_q     <= 1'b0;
      end else if (wr_en && idx == adc_ctrl_pkg::IDX_CLOCK_CTRL) begin
         prescale_q <= wdata[adc_ctrl_pkg::PRESCALE_LSB +: 3];
         gate_q     <= wdata[adc_ctrl_pkg::GATE_BIT];
      end
   end

   // Analog pin routing
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         pin_sel_q <= adc_ctrl_pkg::PIN_SEL_RST;
      end else if (wr_en && idx == adc_ctrl_pkg::IDX_PIN_SELECT) begin
         pin_sel_q <= wdata[adc_ctrl_pkg::PIN_SEL_LSB +: 4];
      end
   end

   // Channel select and one-cycle start pulse
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         chan_q  <= adc_ctrl_pkg::CHAN_RST;
         start_q <= 1'b0;
      end else if (wr_en && idx == adc_ctrl_pkg::IDX_START_CHAN) begin
         chan_q  <= wdata[adc_ctrl_pkg::CHAN_LSB +: 2];
         start_q <= wdata[adc_ctrl_pkg::START_BIT];
      end else begin
         start_q <= 1'b0;
      end
   end

   // Conversion sequencing, busy from start until completion
   always_comb begin
      state_d = state_q;
      case (state_q)
         adc_ctrl_pkg::CONV_IDLE: begin
            if (start_q) begin
               state_d = adc_ctrl_pkg::CONV_BUSY;
            end
         end
         adc_ctrl_pkg::CONV_BUSY: begin
            if (conv_done_i && !start_q) begin
               state_d = adc_ctrl_pkg::CONV_IDLE;
            end
         end
         default: begin
            state_d = adc_ctrl_pkg::CONV_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         state_q <= adc_ctrl_pkg::CONV_IDLE;
      end else begin
         state_q <= state_d;
      end
   end

   // Result capture, whole word in the flag's cycle; no reset needed
   always_ff @(posedge clk_i) begin
      if (conv_done_i) begin
         result_q <= conv_result_i;
      end
   end

   // Control bundle and priority level towards core and CPU
   assign conv_ctrl_o.pin_sel = pin_sel_q;
   assign conv_ctrl_o.channel = chan_q;
   assign conv_ctrl_o.start   = start_q;
   assign conv_ctrl_o.busy    = state_q == adc_ctrl_pkg::CONV_BUSY;
   assign irq_level_o         = prio_q;
   assign readdata_o          = rdata_q;
   assign waitrequest_o       = wait_q;

   // Converter clock prescaler
   adc_prescaler #(
      .CNT_W (adc_ctrl_pkg::PRESCALE_CNT_W)
   ) u_prescaler (
      .clk_i       (clk_i),
      .resetn_i    (resetn_i),
      .fast_tick_i (fast_tick_i),
      .slow_tick_i (slow_tick_i),
      .sel_i       (prescale_q),
      .gate_i      (gate_q),
      .tick_o      (conv_clk_tick_o)
   );

   // Interrupt gating
   adc_irq_gate u_irq_gate (
      .clk_i      (clk_i),
      .resetn_i   (resetn_i),
      .flag_i     (flag_q),
      .enable_i   (enable_q),
      .level_i    (prio_q),
      .cpu_mask_i (cpu_mask_i),
      .irq_o      (irq_o),
      .req_o      (irq_req_o)
   );

   // Bus handshake steps
   sequence bus_req_s;
      (read_i || write_i) && wait_q;
   endsequence
   sequence bus_ack_s;
      !wait_q ##1 wait_q;
   endsequence

   bus_ack_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
      bus_req_s |=> bus_ack_s) else $error("waitrequest handshake broken");

   pin_write_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
      wr_en && idx == 16'hff81 |=> conv_ctrl_o.pin_sel == $past(wdata[7:4]))
      else $error("pin select not stored");

   start_pulse_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
      wr_en && idx == 16'hff82 && wdata[7] |=> start_q && chan_q == $past(wdata[1:0]) ##1 !start_q)
      else $error("start pulse wrong");

   busy_track_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
      start_q |=> conv_ctrl_o.busy) else $error("not busy after start");

   chan_write_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
      wr_en && idx == 16'hff82 |=> chan_q == $past(wdata[1:0]))
      else $error("channel select not stored");

   result_split_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
      rd_cap && idx == 16'hff83 |=> readdata_o == {24'h0, $past(result_q[9:2])})
      else $error("upper result byte misplaced");

   result_low_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
      rd_cap && idx == 16'hff84 |=> readdata_o[7:2] == 6'h0)
      else $error("low result byte upper bits not zero");

   prio_write_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
      wr_en && idx == 16'hff28 |=> irq_level_o == $past(wdata[7:6]))
      else $error("priority not stored");

   enable_block_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
      !enable_q ##1 !enable_q |-> !irq_o) else $error("interrupt while disabled");

   flag_set_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
      conv_done_i |=> flag_q) else $error("flag not set on completion");

   flag_clear_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
      wr_en && idx == 16'hff2c && wdata[7] && !conv_done_i |=> !flag_q)
      else $error("flag not cleared by one");

   flag_hold_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
      flag_q && !(wr_en && idx == 16'hff2c && wdata[7]) |=> flag_q)
      else $error("flag lost without clear");

   result_flag_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
      conv_done_i |=> flag_q && result_q == $past(conv_result_i))
      else $error("result and flag not updated together");
endmodule : adc_control

/* File: adc_core_model.sv */
// Behavioural converter core and oscillator tick source facing the control block
`timescale 1ns/1ps
module adc_core_model #(
   parameter int unsigned CONV_TICKS = 10
) (
   input  wire logic                      clk_i,
   input  wire logic                      resetn_i,
   input  wire adc_ctrl_pkg::conv_ctrl_t  ctrl_i,
   input  wire logic                      conv_tick_i,
   input  wire logic [9:0]                level_i,
   output logic                           fast_tick_o,
   output logic                           slow_tick_o,
   output logic                           done_o,
   output logic [9:0]                     result_o
);
   logic [3:0] osc_q;
   int         left_q;

   // Oscillator ticks: fast every second cycle, slow every sixteenth
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         osc_q <= 4'h0;
      end else begin
         osc_q <= osc_q + 4'h1;
      end
   end
   assign fast_tick_o = osc_q[0];
   assign slow_tick_o = (osc_q == 4'hf);

   // Conversion counts converter clock ticks; no clock means no completion
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         left_q   <= 0;
         done_o   <= 1'b0;
         result_o <= 10'h0;
      end else begin
         done_o   <= 1'b0;
         result_o <= ~result_o;  // Result bus only valid with done
         if (ctrl_i.start) begin
            left_q <= CONV_TICKS;
         end else if (left_q > 0 && conv_tick_i) begin
            left_q <= left_q - 1;
            if (left_q == 1) begin
               done_o   <= 1'b1;
               // Channel not routed as analog gives a wrong value
               result_o <= ctrl_i.pin_sel[ctrl_i.channel] ? level_i : ~level_i;
            end
         end
      end
   end
endmodule : adc_core_model

/* File: adc_control_bench.sv */
// Self-checking bench for the converter control block
`timescale 1ns/1ps
module adc_control_bench;
   typedef struct {
      logic [15:0] idx;
      logic [7:0]  wd;
      logic [7:0]  rd;
      int          sel;
      logic [3:0]  out;
   } row_t;

   logic                      clk_i;
   logic                      resetn_i;
   logic [17:0]               av_address;
   logic                      av_read;
   logic                      av_write;
   logic [31:0]               av_wdata;
   logic [3:0]                av_be;
   logic [31:0]               readdata;
   logic                      waitreq;
   logic                      fast_tick;
   logic                      slow_tick;
   logic                      done;
   logic [9:0]                result;
   adc_ctrl_pkg::conv_ctrl_t  ctrl;
   logic                      conv_tick;
   logic [1:0]                cpu_mask;
   logic [1:0]                irq_level;
   logic                      irq;
   logic                      irq_req;
   logic [9:0]                level;
   logic [31:0]               rd;
   int                        n_errors;
   int                        n_tests;
   int                        cnt;
   int                        exp;
   row_t                      rows [8];

   // Clock at 25 ns period
   initial clk_i = 1'b0;
   always #12.5 clk_i = ~clk_i;

   adc_control i_dut (.clk_i(clk_i), .resetn_i(resetn_i), .address_i(av_address), .read_i(av_read),
      .write_i(av_write), .writedata_i(av_wdata), .byteenable_i(av_be), .readdata_o(readdata),
      .waitrequest_o(waitreq), .fast_tick_i(fast_tick), .slow_tick_i(slow_tick), .conv_done_i(done),
      .conv_result_i(result), .conv_ctrl_o(ctrl), .conv_clk_tick_o(conv_tick), .cpu_mask_i(cpu_mask),
      .irq_level_o(irq_level), .irq_o(irq), .irq_req_o(irq_req));

   adc_core_model i_core (.clk_i(clk_i), .resetn_i(resetn_i), .ctrl_i(ctrl), .conv_tick_i(conv_tick),
      .level_i(level), .fast_tick_o(fast_tick), .slow_tick_o(slow_tick), .done_o(done), .result_o(result));

   task automatic final_report;
      $display("Comparisons %0d mismatches %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : final_report

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] want);
      n_tests++;
      if (seen !== want) begin
         n_errors++;
         $display("Error %s expected %h seen %h", what, want, seen);
      end
   endtask : check

   // One Avalon transfer; entered and left just after a rising edge
   task automatic bus(input logic wr, input logic [15:0] idx, input logic [7:0] wd);
      int n;
      n = 0;
      av_address <= {idx, 2'b00};
      av_wdata   <= {24'h0, wd};
      av_write   <= wr;
      av_read    <= !wr;
      // Waitrequest and read data taken at the rising edge only
      do begin
         @(posedge clk_i);
         n++;
      end while (waitreq !== 1'b0 && n < 100);
      if (n >= 100) begin
         n_errors++;
         final_report();
      end
      rd = readdata;
      av_write <= 1'b0;
      av_read  <= 1'b0;
      // One idle edge before the next request
      @(posedge clk_i);
   endtask : bus

   task automatic reg_is(input string what, input logic [15:0] idx, input logic [7:0] want);
      bus(1'b0, idx, 8'h0);
      check(what, rd, {24'h0, want});
   endtask : reg_is

   // Reset for five cycles, then all registers but the two result registers read zero
   task automatic reset_check;
      resetn_i <= 1'b0;
      repeat (5) @(posedge clk_i);
      resetn_i <= 1'b1;
      @(posedge clk_i);
      reg_is("priority", 16'hff28, 8'h00);
      reg_is("enable", 16'hff2a, 8'h00);
      reg_is("flag", 16'hff2c, 8'h00);
      reg_is("clock", 16'hff80, 8'h00);
      reg_is("pins", 16'hff81, 8'h00);
      reg_is("chan", 16'hff82, 8'h00);
      check("irq", {irq, irq_req}, 32'h0);
      $display("Test reset done");
   endtask : reset_check

   // Start a conversion and wait for busy to fall
   task automatic convert(input logic [1:0] ch, input logic [9:0] lvl);
      int n;
      level <= lvl;
      bus(1'b1, 16'hff82, {6'h20, ch});
      n = 0;
      do begin
         @(negedge clk_i);
         n++;
      end while (ctrl.busy !== 1'b1 && n < 10);
      check("busy", ctrl.busy, 32'h1);
      check("chan out", ctrl.channel, ch);
      while (ctrl.busy !== 1'b0 && n < 3000) begin
         @(negedge clk_i);
         n++;
      end
      if (n >= 3000) begin
         n_errors++;
         final_report();
      end
      repeat (2) @(posedge clk_i);
   endtask : convert

   initial begin
      #(25ns * 60000);
      n_errors++;
      final_report();
   end

   initial begin
      resetn_i = 1'b0;
      av_address = 18'h0;
      av_read = 1'b0;
      av_write = 1'b0;
      av_wdata = 32'h0;
      av_be = 4'hf;
      cpu_mask = 2'h0;
      level = 10'h0;
      rows = '{'{16'hff28, 8'hc0, 8'hc0, 3, 4'h3}, '{16'hff28, 8'h40, 8'h40, 3, 4'h1},
               '{16'hff2a, 8'hff, 8'h80, 0, 4'h0}, '{16'hff80, 8'h0f, 8'h07, 0, 4'h0},
               '{16'hff81, 8'hff, 8'hf0, 1, 4'hf}, '{16'hff81, 8'h50, 8'h50, 1, 4'h5},
               '{16'hff82, 8'h03, 8'h03, 2, 4'h3}, '{16'hff30, 8'hff, 8'h00, 0, 4'h0}};
      @(posedge clk_i);
      reset_check();
      // Register write, read back and output table
      foreach (rows[i]) begin
         bus(1'b1, rows[i].idx, rows[i].wd);
         reg_is("table read", rows[i].idx, rows[i].rd);
         @(posedge clk_i);
         case (rows[i].sel)
            1: check("pin out", ctrl.pin_sel, rows[i].out);
            2: check("chan out", ctrl.channel, rows[i].out);
            3: check("level out", irq_level, rows[i].out);
            default: ;
         endcase
      end
      check("no start", ctrl.busy, 32'h0);
      // Write without low byte enable is ignored
      av_be <= 4'h0;
      bus(1'b1, 16'hff81, 8'hf0);
      av_be <= 4'hf;
      reg_is("no byte", 16'hff81, 8'h50);
      $display("Test table done");
      // Prescaler ratios with gate on, then gate off
      for (int s = 0; s < 9; s++) begin
         bus(1'b1, 16'hff80, (s == 8) ? 8'h00 : {5'h1, s[2:0]});
         repeat (4) @(posedge clk_i);
         cnt = 0;
         repeat (512) begin
            @(negedge clk_i);
            cnt += (conv_tick === 1'b1);
         end
         exp = (s == 8) ? 0 : (s == 7) ? 32 : (256 >> s);
         check("tick count", (cnt >= exp - 1 && cnt <= exp + 1), 32'h1);
      end
      $display("Test prescaler done");
      // Conversions on every channel, slower clock for higher channels
      bus(1'b1, 16'hff2a, 8'h00);
      bus(1'b1, 16'hff81, 8'hf0);
      for (int c = 0; c < 4; c++) begin
         bus(1'b1, 16'hff80, {5'h1, c[2:0]});
         convert(c[1:0], 10'h2d6 ^ {c[1:0], c[1:0], c[1:0], c[1:0], c[1:0]});
         reg_is("result hi", 16'hff83, level[9:2]);
         reg_is("result lo", 16'hff84, {6'h0, level[1:0]});
         reg_is("flag set", 16'hff2c, 8'h80);
         reg_is("start reads 0", 16'hff82, {6'h0, c[1:0]});
         check("irq off", irq, 32'h0);
         bus(1'b1, 16'hff2c, 8'h00);
         reg_is("flag kept", 16'hff2c, 8'h80);
         bus(1'b1, 16'hff2c, 8'h80);
         reg_is("flag clr", 16'hff2c, 8'h00);
      end
      $display("Test conversion done");
      // Interrupt gating by enable, priority and CPU mask
      bus(1'b1, 16'hff28, 8'h80);
      bus(1'b1, 16'hff2a, 8'h80);
      cpu_mask <= 2'h1;
      convert(2'h2, 10'h155);
      check("irq", {irq, irq_req}, 32'h3);
      cpu_mask <= 2'h2;
      repeat (2) @(posedge clk_i);
      check("masked req", {irq, irq_req}, 32'h2);
      cpu_mask <= 2'h1;
      bus(1'b1, 16'hff2a, 8'h00);
      repeat (2) @(posedge clk_i);
      check("disabled", {irq, irq_req}, 32'h0);
      reg_is("flag stays", 16'hff2c, 8'h80);
      bus(1'b1, 16'hff2a, 8'h80);
      repeat (2) @(posedge clk_i);
      check("reenabled", {irq, irq_req}, 32'h3);
      bus(1'b1, 16'hff2c, 8'h80);
      repeat (2) @(posedge clk_i);
      check("cleared", {irq, irq_req}, 32'h0);
      bus(1'b1, 16'hff28, 8'h00);
      cpu_mask <= 2'h0;
      convert(2'h3, 10'h0aa);
      check("level zero", {irq, irq_req}, 32'h2);
      $display("Test interrupt done");
      reset_check();
      final_report();
   end
endmodule : adc_control_bench
